// >>> verilog/apc_pkg.sv
// shared constants for the axis position-initialisation command block
package apc_pkg;

  // ----------------------------------------------------------------
  // command word 5 bit positions
  // ----------------------------------------------------------------
  localparam int CMD_HOME_BIT = 0;
  localparam int CMD_SETHOME_BIT = 1;
  localparam int CMD_RETRACT_BIT = 2;

  // ----------------------------------------------------------------
  // float constants and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FLT_ONE = 32'h3f800000;
  localparam logic [31:0] FLT_ZERO = 32'h00000000;
  localparam logic [31:0] RAMP_RST = FLT_ONE;
  localparam logic [31:0] SPEED_RST = FLT_ZERO;
  localparam logic [31:0] POS_RST = FLT_ZERO;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // answer codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RSP_OK = 8'h00;
  localparam logic [7:0] RSP_ESTOP = 8'h01;
  localparam logic [7:0] RSP_BUSY = 8'h02;
  localparam logic [7:0] RSP_NOT_HOMED = 8'h03;
  localparam logic [7:0] RSP_BAD_CMD = 8'h04;

  // ----------------------------------------------------------------
  // controller register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_WORD4 = 6'h00;
  localparam logic [5:0] REG_WORD5 = 6'h04;
  localparam logic [5:0] REG_PAR_A = 6'h08;
  localparam logic [5:0] REG_PAR_B = 6'h0c;
  localparam logic [5:0] REG_PAR_C = 6'h10;
  localparam logic [5:0] REG_STATUS = 6'h14;
  localparam logic [5:0] REG_CLEAR = 6'h18;
  localparam logic [5:0] REG_ENABLE = 6'h1c;
  localparam logic [5:0] REG_RESULT = 6'h20;

  // status bit layout
  localparam int ST_OK_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_WIDTH = 2;

  typedef enum logic [1:0] {
    APC_IDLE,
    APC_STOPPING,
    APC_HOMING
  } apc_state_type;

endpackage : apc_pkg

// >>> verilog/apc_link_if.sv
// output-image words and answer path between controller and axis module
`timescale 1ns/1ps
interface apc_link_if;
  logic [15:0] word4;
  logic [15:0] word5;
  logic [31:0] par_a;
  logic [31:0] par_b;
  logic [31:0] par_c;
  logic cmd_stb;
  logic rsp_stb;
  logic [7:0] rsp_code;
  logic homed;

  modport dev (
    input word4, word5, par_a, par_b, par_c, cmd_stb,
    output rsp_stb, rsp_code, homed
  );

  modport ctl (
    output word4, word5, par_a, par_b, par_c, cmd_stb,
    input rsp_stb, rsp_code, homed
  );
endinterface : apc_link_if

// >>> verilog/apc_dev.sv
// axis module end: decodes and runs home, set home and set retract commands
`timescale 1ns/1ps
module apc_dev
  import apc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // controller link
  apc_link_if.dev lnk,
  // axis state from the motion side
  input wire logic estop,
  input wire logic motion_busy,
  input wire logic [31:0] following_error,
  input wire logic [31:0] max_speed,
  input wire logic home_done,
  input wire logic home_fault,
  input wire logic [7:0] home_fault_code,
  input wire logic retract_req,
  input wire logic offset_load,
  input wire logic [31:0] offset_val,
  // orders to the motion side
  output logic home_start_r,
  output logic home_dir_r,
  output logic [31:0] home_speed_r,
  output logic [31:0] home_ramp_r,
  output logic cancel_r,
  output logic abs_move_ok_r,
  output logic [31:0] cmd_pos_r,
  output logic [31:0] abs_pos_r,
  output logic [31:0] offset_r,
  output logic retract_go_r,
  output logic [31:0] rt_pos_r,
  output logic [31:0] rt_speed_r,
  output logic [31:0] rt_ramp_r
);

  // ----------------------------------------------------------------
  // float helpers
  // ----------------------------------------------------------------
  // magnitude limited to the configured maximum; sign dropped
  function automatic logic [31:0] clamp_mag(input logic [31:0] v, input logic [31:0] lim);
    logic [31:0] m;
    m = {1'b0, v[30:0]};
    clamp_mag = (m[30:0] > lim[30:0]) ? {1'b0, lim[30:0]} : m;
  endfunction : clamp_mag

  // single precision add, truncating, denormals flushed to zero
  function automatic logic [31:0] fadd(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] x;
    logic [31:0] y;
    logic [7:0] d;
    logic [7:0] e;
    logic [24:0] mx;
    logic [24:0] my;
    logic [24:0] s;
    logic done;
    x = (a[30:0] >= b[30:0]) ? a : b;
    y = (a[30:0] >= b[30:0]) ? b : a;
    d = x[30:23] - y[30:23];
    e = x[30:23];
    mx = (x[30:23] == 8'h00) ? 25'h0000000 : {2'b01, x[22:0]};
    my = (y[30:23] == 8'h00) ? 25'h0000000 : {2'b01, y[22:0]};
    my = (d > 8'h18) ? 25'h0000000 : (my >> d);
    s = (x[31] == y[31]) ? (mx + my) : (mx - my);
    done = 1'b0;
    if (s[24]) begin
      s = s >> 1;
      e = e + 8'h01;
    end
    for (int i = 0; i < 24; i++) begin
      if (!done && !s[23] && s != 25'h0000000 && e > 8'h01) begin
        s = s << 1;
        e = e - 8'h01;
      end else begin
        done = 1'b1;
      end
    end
    if (s == 25'h0000000 || x[30:23] == 8'h00) begin
      fadd = (x[30:23] == 8'h00) ? FLT_ZERO : x;
      if (s == 25'h0000000) fadd = FLT_ZERO;
    end else begin
      fadd = {x[31], e, s[22:0]};
    end
  endfunction : fadd

  // ----------------------------------------------------------------
  // command detection
  // ----------------------------------------------------------------
  logic [15:0] last_w5_r;
  logic rt_req_d_r;
  apc_state_type state_r;
  logic new_cmd;
  logic is_home;
  logic is_sethome;
  logic is_retract;
  logic axis_busy;
  logic retract_edge;

  assign new_cmd = lnk.cmd_stb && lnk.word5 != WORD_RST && lnk.word5 != last_w5_r;
  assign is_home = new_cmd && lnk.word4 == WORD_RST && lnk.word5[CMD_HOME_BIT];
  assign is_sethome = new_cmd && lnk.word4 == WORD_RST && !lnk.word5[CMD_HOME_BIT]
                      && lnk.word5[CMD_SETHOME_BIT];
  assign is_retract = new_cmd && lnk.word4 == WORD_RST && lnk.word5[1:0] == 2'b00
                      && lnk.word5[CMD_RETRACT_BIT];
  assign axis_busy = motion_busy || state_r != APC_IDLE;
  assign retract_edge = retract_req && !rt_req_d_r;

  // remembers the last word5 so a repeat is not run twice
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_w5_r <= WORD_RST;
      rt_req_d_r <= 1'b0;
    end else if (clk_en) begin
      if (lnk.cmd_stb) last_w5_r <= lnk.word5;
      rt_req_d_r <= retract_req;
    end
  end

  // ----------------------------------------------------------------
  // homing sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= APC_IDLE;
      home_start_r <= 1'b0;
      cancel_r <= 1'b0;
      home_dir_r <= 1'b0;
      home_speed_r <= SPEED_RST;
      home_ramp_r <= RAMP_RST;
    end else if (clk_en) begin
      home_start_r <= 1'b0;
      cancel_r <= 1'b0;
      case (state_r)
        APC_IDLE: begin
          if (is_home && !estop) begin
            home_dir_r <= lnk.par_b[31];
            home_speed_r <= clamp_mag(lnk.par_b, max_speed);
            home_ramp_r <= lnk.par_a;
            if (motion_busy) begin
              cancel_r <= 1'b1;
              state_r <= APC_STOPPING;
            end else begin
              home_start_r <= 1'b1;
              state_r <= APC_HOMING;
            end
          end
        end
        APC_STOPPING: begin
          if (estop) begin
            state_r <= APC_IDLE;
          end else if (!motion_busy) begin
            home_start_r <= 1'b1;
            state_r <= APC_HOMING;
          end
        end
        APC_HOMING: begin
          if (home_fault || home_done || estop) state_r <= APC_IDLE;
        end
        default: state_r <= APC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // position, homed flag and offset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      abs_move_ok_r <= 1'b0;
      cmd_pos_r <= POS_RST;
      abs_pos_r <= POS_RST;
      offset_r <= POS_RST;
    end else if (clk_en) begin
      if (is_sethome && !estop && !axis_busy) begin
        cmd_pos_r <= lnk.par_a;
        abs_pos_r <= fadd(lnk.par_a, following_error);
        offset_r <= POS_RST;
        abs_move_ok_r <= 1'b1;
      end else if (state_r == APC_HOMING && home_done && !home_fault && !estop) begin
        offset_r <= POS_RST;
        abs_move_ok_r <= 1'b1;
      end else if (home_start_r) begin
        abs_move_ok_r <= 1'b0;
      end else if (offset_load) begin
        offset_r <= offset_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // retract store and trigger
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rt_pos_r <= POS_RST;
      rt_speed_r <= SPEED_RST;
      rt_ramp_r <= RAMP_RST;
      retract_go_r <= 1'b0;
    end else if (clk_en) begin
      retract_go_r <= retract_edge && abs_move_ok_r && !estop && state_r == APC_IDLE;
      if (is_retract && !estop && !axis_busy && abs_move_ok_r) begin
        rt_ramp_r <= lnk.par_a;
        rt_speed_r <= clamp_mag(lnk.par_b, max_speed);
        rt_pos_r <= lnk.par_c;
      end
    end
  end

  // ----------------------------------------------------------------
  // answers to the controller
  // ----------------------------------------------------------------
  logic rsp_stb_r;
  logic [7:0] rsp_code_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_stb_r <= 1'b0;
      rsp_code_r <= RSP_OK;
    end else if (clk_en) begin
      rsp_stb_r <= 1'b0;
      if (new_cmd) begin
        rsp_stb_r <= 1'b1;
        if (!is_home && !is_sethome && !is_retract) rsp_code_r <= RSP_BAD_CMD;
        else if (estop) rsp_code_r <= RSP_ESTOP;
        else if (is_home) rsp_stb_r <= 1'b0;
        else if (axis_busy) rsp_code_r <= RSP_BUSY;
        else if (is_retract && !abs_move_ok_r) rsp_code_r <= RSP_NOT_HOMED;
        else rsp_code_r <= RSP_OK;
      end else if (state_r == APC_STOPPING && estop) begin
        rsp_stb_r <= 1'b1;
        rsp_code_r <= RSP_ESTOP;
      end else if (state_r == APC_HOMING && (home_fault || home_done || estop)) begin
        rsp_stb_r <= 1'b1;
        rsp_code_r <= home_fault ? home_fault_code : (estop ? RSP_ESTOP : RSP_OK);
      end
    end
  end

  assign lnk.rsp_stb = rsp_stb_r;
  assign lnk.rsp_code = rsp_code_r;
  assign lnk.homed = abs_move_ok_r;

endmodule : apc_dev

// >>> verilog/apc_ctl.sv
// controller end: software writes output-image words over avalon, gets answers
`timescale 1ns/1ps
module apc_ctl
  import apc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // software register port
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq_r,
  // link to the axis module
  apc_link_if.ctl lnk
);

  // ----------------------------------------------------------------
  // image words and register state
  // ----------------------------------------------------------------
  logic [15:0] word4_r;
  logic [15:0] word5_r;
  logic [31:0] par_a_r;
  logic [31:0] par_b_r;
  logic [31:0] par_c_r;
  logic cmd_stb_r;
  logic [ST_WIDTH-1:0] status_r;
  logic [ST_WIDTH-1:0] enable_r;
  logic [7:0] result_r;
  logic [31:0] readdata_r;
  logic waitreq_r;
  logic wr_go;
  logic [ST_WIDTH-1:0] ev;
  logic [ST_WIDTH-1:0] clr;

  // write lands only at the edge where waitrequest is seen low
  assign wr_go = avs_write && !waitreq_r;
  assign ev = {lnk.rsp_stb && lnk.rsp_code != RSP_OK, lnk.rsp_stb && lnk.rsp_code == RSP_OK};
  assign clr = (wr_go && avs_address == REG_CLEAR) ? avs_writedata[ST_WIDTH-1:0] : '0;

  // one wait state per access
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      waitreq_r <= 1'b1;
      readdata_r <= 32'h00000000;
    end else if (clk_en) begin
      waitreq_r <= !((avs_read || avs_write) && waitreq_r);
      if (avs_read && waitreq_r) begin
        case (avs_address)
          REG_WORD4: readdata_r <= {16'h0000, word4_r};
          REG_WORD5: readdata_r <= {16'h0000, word5_r};
          REG_PAR_A: readdata_r <= par_a_r;
          REG_PAR_B: readdata_r <= par_b_r;
          REG_PAR_C: readdata_r <= par_c_r;
          REG_STATUS: readdata_r <= {30'h00000000, status_r};
          REG_ENABLE: readdata_r <= {30'h00000000, enable_r};
          REG_RESULT: readdata_r <= {23'h000000, lnk.homed, result_r};
          default: readdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // image words; a write of word5 sends the whole image once
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      word4_r <= WORD_RST;
      word5_r <= WORD_RST;
      par_a_r <= RAMP_RST;
      par_b_r <= SPEED_RST;
      par_c_r <= POS_RST;
      cmd_stb_r <= 1'b0;
    end else if (clk_en) begin
      cmd_stb_r <= wr_go && avs_address == REG_WORD5;
      if (wr_go && avs_address == REG_WORD4) word4_r <= avs_writedata[15:0];
      if (wr_go && avs_address == REG_WORD5) word5_r <= avs_writedata[15:0];
      if (wr_go && avs_address == REG_PAR_A) par_a_r <= avs_writedata;
      if (wr_go && avs_address == REG_PAR_B) par_b_r <= avs_writedata;
      if (wr_go && avs_address == REG_PAR_C) par_c_r <= avs_writedata;
    end
  end

  // sticky status, set beats clear; level interrupt
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_r <= '0;
      enable_r <= '0;
      result_r <= RSP_OK;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      status_r <= (status_r & ~clr) | ev;
      if (wr_go && avs_address == REG_ENABLE) enable_r <= avs_writedata[ST_WIDTH-1:0];
      if (lnk.rsp_stb) result_r <= lnk.rsp_code;
      irq_r <= |(((status_r & ~clr) | ev) & enable_r);
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign lnk.word4 = word4_r;
  assign lnk.word5 = word5_r;
  assign lnk.par_a = par_a_r;
  assign lnk.par_b = par_b_r;
  assign lnk.par_c = par_c_r;
  assign lnk.cmd_stb = cmd_stb_r;

endmodule : apc_ctl

// >>> dv/apc_link_checker.sv
// concurrent checks on the link between controller end and axis end
`timescale 1ns/1ps
module apc_link_checker
  import apc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // image words
  input wire logic [15:0] word4,
  input wire logic [15:0] word5,
  input wire logic [31:0] par_a,
  input wire logic [31:0] par_b,
  input wire logic [31:0] par_c,
  input wire logic cmd_stb,
  // answers
  input wire logic rsp_stb,
  input wire logic [7:0] rsp_code,
  input wire logic homed
);
  // ----------------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------------
  logic [15:0] last_w5_r;
  logic fresh;
  logic sel_home;
  logic sel_set;
  logic sel_rt;
  logic sel_bad;

  // last strobed word 5, zero included
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_w5_r <= WORD_RST;
    end else if (cmd_stb) begin
      last_w5_r <= word5;
    end
  end

  // new nonzero command and which one it selects
  assign fresh = cmd_stb && word5 != 16'h0000 && word5 != last_w5_r;
  assign sel_home = fresh && word4 == 16'h0000 && word5[CMD_HOME_BIT];
  assign sel_set = fresh && word4 == 16'h0000 && word5[2:0] == 3'b010;
  assign sel_rt = fresh && word4 == 16'h0000 && word5[2:0] == 3'b100;
  assign sel_bad = fresh && (word4 != 16'h0000 || word5[2:0] == 3'b000);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  rsp_one_cycle_a: assert property (rsp_stb |=> !rsp_stb)
    else $error("answer strobe longer than one cycle");
  quick_answer_a: assert property ((sel_set || sel_rt) |=> rsp_stb)
    else $error("set home or set retract not answered next cycle");
  bad_select_a: assert property (sel_bad |=> rsp_stb && rsp_code == RSP_BAD_CMD)
    else $error("bad selection not answered with bad command code");
  repeat_ignored_a: assert property (cmd_stb && (word5 == 16'h0000 || word5 == last_w5_r) |=> !rsp_stb)
    else $error("zero or repeated word 5 answered");
  home_not_instant_a: assert property (sel_home |=> !(rsp_stb && rsp_code == RSP_OK))
    else $error("home reported done without a move");
  set_home_marks_a: assert property (sel_set ##1 rsp_code == RSP_OK |-> homed)
    else $error("set home succeeded but axis not homed");
  homed_rise_a: assert property ($rose(homed) |-> rsp_stb && rsp_code == RSP_OK)
    else $error("homed rose without a good answer");
  code_holds_a: assert property (!rsp_stb |-> $stable(rsp_code))
    else $error("answer code changed without strobe");
  retract_homed_a: assert property (sel_rt && !homed |=> rsp_code != RSP_OK)
    else $error("retract accepted on unhomed axis");

  // main scenarios reached
  cover property (sel_set ##1 rsp_code == RSP_OK);
  cover property (sel_home ##[2:300] rsp_stb && rsp_code == RSP_OK);
  cover property (sel_bad);
  cover property (cmd_stb && word5 == last_w5_r && word5 != 16'h0000);
endmodule : apc_link_checker

// >>> dv/apc_tb_top.sv
// self-checking testbench joining controller end and axis end
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module apc_tb_top
  import apc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [31:0] F_M1 = 32'hbf800000;
  localparam logic [31:0] F_H = 32'h3f000000;
  localparam logic [31:0] F_MH = 32'hbf000000;
  localparam logic [31:0] F_50 = 32'h42480000;
  localparam logic [31:0] F_M20 = 32'hc1a00000;
  localparam logic [31:0] F_100 = 32'h42c80000;
  localparam logic [31:0] F_M200 = 32'hc3480000;
  localparam logic [31:0] F_20 = 32'h41a00000;
  localparam logic [31:0] F_Q3 = 32'h3f400000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq_r;
  logic estop = 1'b0;
  logic motion_busy = 1'b0;
  logic home_done = 1'b0;
  logic home_fault = 1'b0;
  logic retract_req = 1'b0;
  logic offset_load = 1'b0;
  logic [31:0] following_error = 32'h0;
  logic [31:0] max_speed = F_100;
  logic [31:0] offset_val = 32'h0;
  logic [7:0] home_fault_code = 8'h00;
  logic home_start_r, home_dir_r, cancel_r, abs_move_ok_r, retract_go_r;
  logic [31:0] home_speed_r, home_ramp_r, cmd_pos_r, abs_pos_r, offset_r, rt_pos_r, rt_speed_r, rt_ramp_r;
  logic [7:0] code_seen;
  logic [31:0] rdat;
  int n_errors = 0;
  int total_checks = 0;
  int rsp_cnt = 0;
  int start_cnt = 0;
  int cancel_cnt = 0;
  int go_cnt = 0;
  int rsp_base = 0;
  int base = 0;
  int base2 = 0;

  apc_link_if u_apc_link_if();
  apc_ctl u_apc_ctl(.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_r(irq_r), .lnk(u_apc_link_if));
  apc_dev u_apc_dev(.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .lnk(u_apc_link_if), .estop(estop),
    .motion_busy(motion_busy), .following_error(following_error), .max_speed(max_speed), .home_done(home_done),
    .home_fault(home_fault), .home_fault_code(home_fault_code), .retract_req(retract_req),
    .offset_load(offset_load), .offset_val(offset_val), .home_start_r(home_start_r), .home_dir_r(home_dir_r),
    .home_speed_r(home_speed_r), .home_ramp_r(home_ramp_r), .cancel_r(cancel_r), .abs_move_ok_r(abs_move_ok_r),
    .cmd_pos_r(cmd_pos_r), .abs_pos_r(abs_pos_r), .offset_r(offset_r), .retract_go_r(retract_go_r),
    .rt_pos_r(rt_pos_r), .rt_speed_r(rt_speed_r), .rt_ramp_r(rt_ramp_r));
  apc_link_checker u_apc_link_checker(.clk_sys(clk_sys), .sys_rst(sys_rst), .word4(u_apc_link_if.word4),
    .word5(u_apc_link_if.word5), .par_a(u_apc_link_if.par_a), .par_b(u_apc_link_if.par_b),
    .par_c(u_apc_link_if.par_c), .cmd_stb(u_apc_link_if.cmd_stb), .rsp_stb(u_apc_link_if.rsp_stb),
    .rsp_code(u_apc_link_if.rsp_code), .homed(u_apc_link_if.homed));

  // clock and pulse counters
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (u_apc_link_if.rsp_stb === 1'b1) begin
      rsp_cnt++;
      code_seen = u_apc_link_if.rsp_code;
    end
    if (home_start_r === 1'b1) start_cnt++;
    if (cancel_r === 1'b1) cancel_cnt++;
    if (retract_go_r === 1'b1) go_cnt++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // one avalon access, held until waitrequest samples low
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : acc

  // load image words, word 5 last so its write sends the image
  task automatic send(input logic [15:0] w4, input logic [15:0] w5, input logic [31:0] pa, pb, pc);
    acc(1'b1, REG_WORD5, 32'h0);
    rsp_base = rsp_cnt;
    acc(1'b1, REG_PAR_A, pa);
    acc(1'b1, REG_PAR_B, pb);
    acc(1'b1, REG_PAR_C, pc);
    acc(1'b1, REG_WORD4, {16'h0000, w4});
    acc(1'b1, REG_WORD5, {16'h0000, w5});
  endtask : send

  // wait for the next answer, then compare its code; the watchdog bounds a hang
  task automatic answer(input logic [7:0] ex);
    while (rsp_cnt == rsp_base) @(posedge clk_sys);
    `CHK("answer code", ex, code_seen)
  endtask : answer

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("ramp default", FLT_ONE, u_apc_link_if.par_a)
    `CHK("homed at reset", 1'b0, u_apc_link_if.homed)
    acc(1'b0, 6'h3c, 32'h0);
    `CHK("unmapped read", 32'h0, rdat)
    $display("test reset done");
    acc(1'b1, REG_ENABLE, 32'h2);
    send(16'h0, 16'h4, F_H, F_50, F_M20);
    answer(RSP_NOT_HOMED);
    acc(1'b0, REG_STATUS, 32'h0);
    `CHK("error status", 32'h2, rdat)
    `CHK("irq raised", 1'b1, irq_r)
    acc(1'b1, REG_ENABLE, 32'h0);
    repeat (2) @(posedge clk_sys);
    `CHK("irq masked", 1'b0, irq_r)
    acc(1'b1, REG_ENABLE, 32'h2);
    acc(1'b1, REG_CLEAR, 32'h2);
    repeat (2) @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq_r)
    $display("test retract unhomed done");
    estop <= 1'b1;
    send(16'h0, 16'h2, F_M1, 32'h0, 32'h0);
    answer(RSP_ESTOP);
    estop <= 1'b0;
    motion_busy <= 1'b1;
    send(16'h0, 16'h2, F_M1, 32'h0, 32'h0);
    answer(RSP_BUSY);
    motion_busy <= 1'b0;
    `CHK("still unhomed", 1'b0, u_apc_link_if.homed)
    $display("test set home refused done");
    offset_val <= 32'h40800000;
    offset_load <= 1'b1;
    @(posedge clk_sys);
    offset_load <= 1'b0;
    following_error <= F_H;
    @(posedge clk_sys);
    `CHK("offset loaded", 32'h40800000, offset_r)
    send(16'h0, 16'h2, F_M1, 32'h0, 32'h0);
    answer(RSP_OK);
    `CHK("cmd position", F_M1, cmd_pos_r)
    `CHK("abs position", F_MH, abs_pos_r)
    `CHK("offset cleared", 32'h0, offset_r)
    `CHK("abs moves ok", 1'b1, abs_move_ok_r)
    acc(1'b0, REG_RESULT, 32'h0);
    `CHK("result word", 32'h100, rdat)
    rsp_base = rsp_cnt;
    acc(1'b1, REG_WORD5, 32'h2);
    repeat (10) @(posedge clk_sys);
    `CHK("repeat ignored", rsp_base, rsp_cnt)
    $display("test set home done");
    send(16'h1, 16'h1, FLT_ONE, F_20, 32'h0);
    answer(RSP_BAD_CMD);
    send(16'h0, 16'h8, FLT_ONE, F_20, 32'h0);
    answer(RSP_BAD_CMD);
    $display("test bad select done");
    send(16'h0, 16'h4, F_H, F_50, F_M20);
    answer(RSP_OK);
    `CHK("rt ramp", F_H, rt_ramp_r)
    `CHK("rt speed", F_50, rt_speed_r)
    `CHK("rt position", F_M20, rt_pos_r)
    base = go_cnt;
    retract_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    retract_req <= 1'b0;
    `CHK("retract run", base + 1, go_cnt)
    @(posedge clk_sys);
    clk_en <= 1'b0;
    base = go_cnt;
    @(posedge clk_sys);
    retract_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    retract_req <= 1'b0;
    clk_en <= 1'b1;
    `CHK("frozen retract", base, go_cnt)
    $display("test retract done");
    base = start_cnt;
    send(16'h0, 16'h1, F_Q3, F_M200, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK("home start", base + 1, start_cnt)
    `CHK("home dir", 1'b1, home_dir_r)
    `CHK("home speed", F_100, home_speed_r)
    `CHK("home ramp", F_Q3, home_ramp_r)
    home_done <= 1'b1;
    @(posedge clk_sys);
    home_done <= 1'b0;
    answer(RSP_OK);
    `CHK("homed", 1'b1, u_apc_link_if.homed)
    $display("test home idle done");
    motion_busy <= 1'b1;
    base = cancel_cnt;
    base2 = start_cnt;
    send(16'h0, 16'h1, FLT_ONE, F_20, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK("cancel", base + 1, cancel_cnt)
    `CHK("wait for stop", base2, start_cnt)
    motion_busy <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("start after stop", base2 + 1, start_cnt)
    `CHK("home dir pos", 1'b0, home_dir_r)
    `CHK("home speed", F_20, home_speed_r)
    home_fault_code <= 8'h42;
    home_fault <= 1'b1;
    @(posedge clk_sys);
    home_fault <= 1'b0;
    answer(8'h42);
    $display("test home busy done");
    estop <= 1'b1;
    base = start_cnt;
    send(16'h0, 16'h1, FLT_ONE, F_20, 32'h0);
    answer(RSP_ESTOP);
    `CHK("no start in estop", base, start_cnt)
    estop <= 1'b0;
    $display("test home estop done");
    results();
  end
endmodule : apc_tb_top
